// file: fcer_pkg.sv
// Constants and types for the fetch control and exception registers
package fcer_pkg;

  // ----------------------------------------------------------------
  // Register selection and control-word write layout
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FCER_SEL_CTRL = 2'h0,
    FCER_SEL_EXCEPTION_RETURN_ADDRESS = 2'h1,
    FCER_SEL_SUMMARY = 2'h2,
    FCER_SEL_NONE = 2'h3
  } fcer_sel_t;

  localparam int W_ASN_LSB = 47;
  localparam int W_RES_HI = 46;
  localparam int W_COUNTER_ENABLE_LSB = 44;
  localparam int W_RES_MID = 43;
  localparam int W_FPE = 42;
  localparam int W_MAP = 41;
  localparam int W_HWE = 40;
  localparam int W_DI = 39;
  localparam int W_BHE = 38;
  localparam int W_JSE = 37;
  localparam int W_BPE = 36;
  localparam int W_PIPE = 35;
  localparam int W_MUX1_LSB = 32;
  localparam int W_MUX0_LSB = 8;
  localparam int W_RES_LO = 4;
  localparam int W_PC0 = 3;
  localparam int W_PC1 = 0;

  // ----------------------------------------------------------------
  // Control-word read layout and summary layout
  // ----------------------------------------------------------------
  localparam int R_RES_HI = 34;
  localparam int R_ASN_LSB = 28;
  localparam int R_RES_MID = 27;
  localparam int R_COUNTER_ENABLE_LSB = 25;
  localparam int R_RES_LO = 24;
  localparam int R_FPE = 23;
  localparam int R_MAP = 22;
  localparam int R_HWE = 21;
  localparam int R_DI = 20;
  localparam int R_BHE = 19;
  localparam int R_JSE = 18;
  localparam int R_BPE = 17;
  localparam int R_PIPE = 16;
  localparam int R_MUX1_LSB = 13;
  localparam int R_MUX0_LSB = 9;
  localparam int R_PC1 = 2;
  localparam int R_PC0 = 1;
  localparam int S_MSK = 33;
  localparam int S_KIND_LSB = 3;
  localparam int S_SWC = 2;
  localparam int EA_PAL = 0;
  localparam int EA_EXACT = 1;
  localparam logic [63:0] FCALL_STEP = 64'h0000_0000_0000_0004;
  localparam logic [1:0] SUPERPAGE_TAG = 2'h2;

  // Counter terminal masks: index 0 is counter 0, index 1 counter 1
  localparam logic [15:0] CNT_TERM_SET0 = 16'h0fff;
  localparam logic [15:0] CNT_TERM_CLR0 = 16'hffff;
  localparam logic [15:0] CNT_TERM_SET1 = 16'h00ff;
  localparam logic [15:0] CNT_TERM_CLR1 = 16'h0fff;

  typedef enum logic [2:0] {
    FCER_ENT_OTHER = 3'h0,
    FCER_ENT_FCALL = 3'h1,
    FCER_ENT_ARITHMETIC_TRAP_ENTRY = 3'h2,
    FCER_ENT_MACHINE_CHECK_ENTRY = 3'h3,
    FCER_ENT_RESET = 3'h4
  } fcer_entry_t;

  typedef enum logic [1:0] {
    FCER_PRED_NOT_TAKEN = 2'h0,
    FCER_PRED_DISP_SIGN = 2'h1,
    FCER_PRED_HISTORY = 2'h2
  } fcer_pred_t;

  // Write-mask shift delay walks 00 -> 01 -> 11 -> 00
  typedef enum logic [1:0] {
    FCER_MS_IDLE = 2'b00,
    FCER_MS_WAIT1 = 2'b01,
    FCER_MS_WAIT2 = 2'b11
  } fcer_ms_t;

endpackage : fcer_pkg

// file: fcer_regs.sv
// Fetch unit control, exception return address and exception summary
`timescale 1ns/100ps
module fcer_regs
  import fcer_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic mtpr_valid,
  input wire logic mfpr_valid,
  input wire fcer_pkg::fcer_sel_t ipr_sel,
  input wire logic [63:0] ipr_wdata,
  output logic [63:0] ipr_rdata,
  output logic ipr_rvalid,
  input wire logic pal_mode,
  input wire logic kernel_mode,
  input wire logic issue_reserved,
  input wire logic issue_float,
  output logic illegal_opcode_fault,
  output logic float_disabled_fault,
  output logic translation_reg_access_ok,
  output logic [5:0] fill_tag,
  input wire logic [5:0] fetch_tag,
  input wire logic fetch_asm,
  input wire logic fetch_hit_raw,
  output logic fetch_valid,
  input wire logic [42:13] fetch_vpc,
  input wire logic [33:13] itb_pa,
  input wire logic itb_asm,
  output logic [33:13] fetch_pa,
  output logic fill_asm,
  output logic dual_issue_allow,
  output fcer_pkg::fcer_pred_t predict_mode,
  input wire logic subroutine_call,
  output logic return_push,
  input wire logic issue_interlocked,
  input wire logic issue_exempt,
  input wire logic pipe_empty,
  input wire logic write_buffer_empty,
  output logic issue_stall,
  output logic [2:0] counter1_event_select,
  output logic [3:0] counter0_event_select,
  input wire logic [1:0] count_event,
  output logic [1:0] counter_irq,
  input wire logic exc_entry,
  input wire fcer_pkg::fcer_entry_t exc_kind,
  input wire logic [63:0] exc_pc,
  input wire logic exc_pc_exact,
  input wire logic firmware_return,
  output logic [63:0] return_target,
  output logic return_to_native,
  input wire logic trap_valid,
  input wire logic [5:0] trap_kinds,
  input wire logic trap_float,
  input wire logic trap_swc_mod,
  input wire logic [5:0] trap_dest
);

  // ----------------------------------------------------------------
  // Control word
  // ----------------------------------------------------------------
  logic [5:0] asn_r, asn_nxt;
  logic pc0_thr_r, pc0_thr_nxt, pc1_thr_r, pc1_thr_nxt;
  logic [1:0] counter_enable_r, counter_enable_nxt;
  logic fpe_r, fpe_nxt, map_r, map_nxt, hwe_r, hwe_nxt;
  logic di_r, di_nxt, bhe_r, bhe_nxt, jse_r, jse_nxt;
  logic bpe_r, bpe_nxt, pipe_r, pipe_nxt;
  logic [2:0] mux1_r, mux1_nxt, res_r, res_nxt;
  logic [3:0] mux0_r, mux0_nxt;
  logic wr_ctrl;

  assign wr_ctrl = mtpr_valid && ipr_sel == FCER_SEL_CTRL;

  always_comb
  begin
    asn_nxt = asn_r;
    pc0_thr_nxt = pc0_thr_r;
    pc1_thr_nxt = pc1_thr_r;
    {counter_enable_nxt, fpe_nxt, map_nxt, hwe_nxt} = {counter_enable_r, fpe_r, map_r, hwe_r};
    {di_nxt, bhe_nxt, jse_nxt, bpe_nxt} = {di_r, bhe_r, jse_r, bpe_r};
    {pipe_nxt, mux1_nxt, mux0_nxt, res_nxt} = {pipe_r, mux1_r, mux0_r, res_r};
    if (wr_ctrl)
    begin
      asn_nxt = ipr_wdata[W_ASN_LSB +: 6];
      pc0_thr_nxt = ipr_wdata[W_PC0];
      pc1_thr_nxt = ipr_wdata[W_PC1];
      counter_enable_nxt = ipr_wdata[W_COUNTER_ENABLE_LSB +: 2];
      fpe_nxt = ipr_wdata[W_FPE];
      map_nxt = ipr_wdata[W_MAP];
      hwe_nxt = ipr_wdata[W_HWE];
      di_nxt = ipr_wdata[W_DI];
      bhe_nxt = ipr_wdata[W_BHE];
      jse_nxt = ipr_wdata[W_JSE];
      bpe_nxt = ipr_wdata[W_BPE];
      pipe_nxt = ipr_wdata[W_PIPE];
      mux1_nxt = ipr_wdata[W_MUX1_LSB +: 3];
      mux0_nxt = ipr_wdata[W_MUX0_LSB +: 4];
      // Reserved bits simply held
      res_nxt = {ipr_wdata[W_RES_HI], ipr_wdata[W_RES_MID],
                 ipr_wdata[W_RES_LO]};
    end
  end

  // No reset here: tag and thresholds survive a chip reset
  always_ff @(posedge mclk)
  begin
    asn_r <= asn_nxt;
    pc0_thr_r <= pc0_thr_nxt;
    pc1_thr_r <= pc1_thr_nxt;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      {counter_enable_r, fpe_r, map_r, hwe_r} <= '0;
      {di_r, bhe_r, jse_r, bpe_r} <= '0;
      {pipe_r, mux1_r, mux0_r, res_r} <= '0;
    end
    else
    begin
      {counter_enable_r, fpe_r, map_r, hwe_r} <= {counter_enable_nxt, fpe_nxt, map_nxt, hwe_nxt};
      {di_r, bhe_r, jse_r, bpe_r} <= {di_nxt, bhe_nxt, jse_nxt, bpe_nxt};
      {pipe_r, mux1_r, mux0_r, res_r} <= {pipe_nxt, mux1_nxt, mux0_nxt,
                                          res_nxt};
    end
  end

  // ----------------------------------------------------------------
  // Issue and fetch controls
  // ----------------------------------------------------------------
  logic sp_active;

  // Enable bit never opens the translation registers
  assign illegal_opcode_fault = issue_reserved && !pal_mode &&
                                !(hwe_r && kernel_mode);
  assign translation_reg_access_ok = pal_mode;
  assign float_disabled_fault = issue_float && !fpe_r;
  assign fill_tag = asn_r;
  assign sp_active = map_r && kernel_mode &&
                     fetch_vpc[42:41] == SUPERPAGE_TAG;
  assign fetch_pa = sp_active ? fetch_vpc[33:13] : itb_pa;
  assign fill_asm = sp_active || itb_asm;
  assign fetch_valid = fetch_hit_raw &&
                       (fetch_asm || fetch_tag == asn_r);
  assign dual_issue_allow = di_r;
  assign predict_mode = !bpe_r ? FCER_PRED_NOT_TAKEN :
                        (bhe_r ? FCER_PRED_HISTORY :
                         FCER_PRED_DISP_SIGN);
  assign return_push = subroutine_call && jse_r;
  assign issue_stall = issue_interlocked && !pipe_r && !issue_exempt &&
                       !(pipe_empty && write_buffer_empty);
  assign counter1_event_select = mux1_r;
  assign counter0_event_select = mux0_r;

  // ----------------------------------------------------------------
  // Performance counters
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_cnt
      // Per-counter state kept local so each register has one driver
      logic [15:0] cnt_r, cnt_nxt, term;
      logic irq_r, irq_nxt, thr, hit;
      assign thr = (gi == 0) ? pc0_thr_r : pc1_thr_r;
      assign term = (gi == 0) ? (thr ? CNT_TERM_SET0 : CNT_TERM_CLR0) :
                    (thr ? CNT_TERM_SET1 : CNT_TERM_CLR1);
      assign hit = count_event[gi] && (|counter_enable_r);
      always_comb
      begin
        cnt_nxt = hit ? cnt_r + 16'h0001 : cnt_r;
        irq_nxt = hit && ((cnt_r & term) == term);
      end
      always_ff @(posedge mclk)
      begin
        if (!resetn)
        begin
          cnt_r <= '0;
          irq_r <= 1'b0;
        end
        else
        begin
          cnt_r <= cnt_nxt;
          irq_r <= irq_nxt;
        end
      end
      assign counter_irq[gi] = irq_r;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Exception return address
  // ----------------------------------------------------------------
  logic [63:0] ea_r, ea_nxt, fcall_pc;

  assign fcall_pc = exc_pc + FCALL_STEP;

  always_comb
  begin
    ea_nxt = ea_r;
    if (mtpr_valid && ipr_sel == FCER_SEL_EXCEPTION_RETURN_ADDRESS)
      ea_nxt = ipr_wdata;
    // Hardware entry outranks a software write in the same cycle
    if (exc_entry)
    begin
      case (exc_kind)
        FCER_ENT_FCALL:
          ea_nxt = {fcall_pc[63:2], 1'b0, pal_mode};
        FCER_ENT_ARITHMETIC_TRAP_ENTRY, FCER_ENT_MACHINE_CHECK_ENTRY:
          ea_nxt = {exc_pc[63:2], exc_pc_exact, pal_mode};
        FCER_ENT_RESET:
          ea_nxt = exc_pc;
        default:
          ea_nxt = {exc_pc[63:2], 1'b0, pal_mode};
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      ea_r <= '0;
    else
      ea_r <= ea_nxt;
  end

  assign return_target = ea_r;
  assign return_to_native = firmware_return && !ea_r[EA_PAL];

  // ----------------------------------------------------------------
  // Exception summary and write mask
  // ----------------------------------------------------------------
  logic [5:0] kind_r, kind_nxt;
  logic swc_r, swc_nxt, swc_broken_r, swc_broken_nxt;
  logic [63:0] mask_r, mask_nxt;
  fcer_ms_t ms_r, ms_nxt;
  logic wr_sum, rd_sum;

  assign wr_sum = mtpr_valid && ipr_sel == FCER_SEL_SUMMARY;
  assign rd_sum = mfpr_valid && ipr_sel == FCER_SEL_SUMMARY;

  always_comb
  begin
    kind_nxt = wr_sum ? '0 : kind_r;
    swc_nxt = wr_sum ? 1'b0 : swc_r;
    swc_broken_nxt = wr_sum ? 1'b0 : swc_broken_r;
    // A trap in the clearing cycle still lands
    if (trap_valid)
    begin
      kind_nxt = kind_nxt | trap_kinds;
      if (trap_float && !trap_swc_mod)
      begin
        swc_nxt = 1'b0;
        swc_broken_nxt = 1'b1;
      end
      else if (trap_float && !swc_broken_nxt)
        swc_nxt = 1'b1;
    end
    mask_nxt = mask_r;
    case (ms_r)
      FCER_MS_IDLE:
        ms_nxt = rd_sum ? FCER_MS_WAIT1 : FCER_MS_IDLE;
      FCER_MS_WAIT1:
        ms_nxt = FCER_MS_WAIT2;
      FCER_MS_WAIT2:
      begin
        ms_nxt = FCER_MS_IDLE;
        mask_nxt = {mask_r[62:0], 1'b0};
      end
      default:
        ms_nxt = FCER_MS_IDLE;
    endcase
    if (trap_valid)
      mask_nxt[trap_dest] = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      kind_r <= '0;
      swc_r <= 1'b0;
      swc_broken_r <= 1'b0;
      mask_r <= '0;
      ms_r <= FCER_MS_IDLE;
    end
    else
    begin
      kind_r <= kind_nxt;
      swc_r <= swc_nxt;
      swc_broken_r <= swc_broken_nxt;
      mask_r <= mask_nxt;
      ms_r <= ms_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [63:0] rdata_r, rdata_nxt;
  logic rvalid_r;

  always_comb
  begin
    rdata_nxt = '0;
    case (ipr_sel)
      FCER_SEL_CTRL:
      begin
        rdata_nxt[R_ASN_LSB +: 6] = asn_r;
        rdata_nxt[R_COUNTER_ENABLE_LSB +: 2] = counter_enable_r;
        {rdata_nxt[R_RES_HI], rdata_nxt[R_RES_MID],
         rdata_nxt[R_RES_LO]} = res_r;
        rdata_nxt[R_FPE:R_PIPE] = {fpe_r, map_r, hwe_r, di_r, bhe_r,
                                   jse_r, bpe_r, pipe_r};
        rdata_nxt[R_MUX1_LSB +: 3] = mux1_r;
        rdata_nxt[R_MUX0_LSB +: 4] = mux0_r;
        rdata_nxt[R_PC1] = pc1_thr_r;
        rdata_nxt[R_PC0] = pc0_thr_r;
      end
      FCER_SEL_EXCEPTION_RETURN_ADDRESS:
        rdata_nxt = ea_r;
      FCER_SEL_SUMMARY:
      begin
        rdata_nxt[S_MSK] = mask_r[63];
        rdata_nxt[S_KIND_LSB +: 6] = kind_r;
        rdata_nxt[S_SWC] = swc_r;
      end
      default:
        rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r <= mfpr_valid ? rdata_nxt : rdata_r;
      rvalid_r <= mfpr_valid;
    end
  end

  assign ipr_rdata = rdata_r;
  assign ipr_rvalid = rvalid_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reset_clear;
    @(posedge mclk) !resetn |=> (fpe_r == 1'b0 && counter_enable_r == 2'h0 &&
                                 pipe_r == 1'b0 && mux0_r == 4'h0);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("control not cleared by reset");
  property p_reserved;
    @(posedge mclk) disable iff (!resetn)
    (issue_reserved && !pal_mode && !hwe_r) |-> illegal_opcode_fault;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved instruction not faulted");
  property p_tag;
    @(posedge mclk) disable iff (!resetn)
    (fetch_tag != asn_r && !fetch_asm) |-> !fetch_valid;
  endproperty
  a_tag: assert property (p_tag)
    else $error("mismatched tag fetch accepted");
  property p_cnt_off;
    @(posedge mclk) disable iff (!resetn)
    (counter_enable_r == 2'h0 && !wr_ctrl) |=> $stable(g_cnt[0].cnt_r);
  endproperty
  a_cnt_off: assert property (p_cnt_off)
    else $error("counter ran while disabled");
  property p_float;
    @(posedge mclk) disable iff (!resetn)
    float_disabled_fault |-> (issue_float && !fpe_r);
  endproperty
  a_float: assert property (p_float)
    else $error("float fault with float enabled");
  property p_fcall;
    @(posedge mclk) disable iff (!resetn)
    (exc_entry && exc_kind == FCER_ENT_FCALL) |=>
      ea_r[63:2] == $past(fcall_pc[63:2]) && !ea_r[EA_EXACT];
  endproperty
  a_fcall: assert property (p_fcall)
    else $error("firmware call saved wrong address");
  property p_kind_sticky;
    @(posedge mclk) disable iff (!resetn)
    (kind_r[0] && !wr_sum) |=> kind_r[0];
  endproperty
  a_kind_sticky: assert property (p_kind_sticky)
    else $error("trap kind lost without write");
  property p_sum_write;
    @(posedge mclk) disable iff (!resetn)
    (wr_sum && !trap_valid && ms_r != FCER_MS_WAIT2) |=>
      kind_r == 6'h00 && !swc_r &&
                                mask_r[63] == $past(mask_r[63]);
  endproperty
  a_sum_write: assert property (p_sum_write)
    else $error("summary write misbehaved");
  property p_msk_shift;
    @(posedge mclk) disable iff (!resetn)
    (rd_sum && ms_r == FCER_MS_IDLE && !trap_valid)
      ##1 (!trap_valid && !rd_sum) [*2]
      |=> mask_r == {$past(mask_r[62:0], 3), 1'b0};
  endproperty
  a_msk_shift: assert property (p_msk_shift)
    else $error("mask not shifted three cycles after read");
  property p_sum_read;
    @(posedge mclk) disable iff (!resetn)
    rd_sum |=> ipr_rdata[S_MSK] == $past(mask_r[63]) &&
               ipr_rdata[32:9] == 24'h000000;
  endproperty
  a_sum_read: assert property (p_sum_read)
    else $error("summary read layout wrong");

  c_superpage: cover property (@(posedge mclk) disable iff (!resetn)
    sp_active && fetch_valid);
  c_irq0: cover property (@(posedge mclk) disable iff (!resetn)
    counter_irq[0]);
  c_drain: cover property (@(posedge mclk) disable iff (!resetn)
    rd_sum ##3 rd_sum);

endmodule : fcer_regs

// file: fcer_regs_bench.sv
// Self-checking bench for the fetch control and exception registers
`timescale 1ns/100ps
module fcer_regs_bench;
  import fcer_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk, resetn, mtpr_valid, mfpr_valid, ipr_rvalid;
  fcer_sel_t ipr_sel;
  logic [63:0] ipr_wdata, ipr_rdata, exc_pc, return_target;
  logic pal_mode, kernel_mode, issue_reserved, issue_float;
  logic illegal_opcode_fault, float_disabled_fault;
  logic translation_reg_access_ok;
  logic [5:0] fill_tag, fetch_tag, trap_kinds, trap_dest;
  logic fetch_asm, fetch_hit_raw, fetch_valid, itb_asm, fill_asm;
  logic [42:13] fetch_vpc;
  logic [33:13] itb_pa, fetch_pa;
  logic dual_issue_allow, subroutine_call, return_push;
  fcer_pred_t predict_mode;
  logic issue_interlocked, issue_exempt, pipe_empty, write_buffer_empty;
  logic issue_stall, exc_entry, exc_pc_exact, firmware_return;
  logic [2:0] counter1_event_select;
  logic [3:0] counter0_event_select;
  logic [1:0] count_event, counter_irq;
  fcer_entry_t exc_kind;
  logic return_to_native, trap_valid, trap_float, trap_swc_mod;
  int n_errors, samples_checked;
  // Current control settings, shared by the helpers below
  logic [5:0] tg;
  logic [1:0] en;
  logic [7:0] c8;
  logic [2:0] m1;
  logic [3:0] m0;
  logic p0, p1;
  logic [7:0] c8s [4] = '{8'hff, 8'h00, 8'h96, 8'h69};

  fcer_regs dut
  (
    .mclk, .resetn, .mtpr_valid, .mfpr_valid, .ipr_sel, .ipr_wdata,
    .ipr_rdata, .ipr_rvalid, .pal_mode, .kernel_mode, .issue_reserved,
    .issue_float, .illegal_opcode_fault, .float_disabled_fault,
    .translation_reg_access_ok, .fill_tag, .fetch_tag, .fetch_asm,
    .fetch_hit_raw, .fetch_valid, .fetch_vpc, .itb_pa, .itb_asm,
    .fetch_pa, .fill_asm, .dual_issue_allow, .predict_mode,
    .subroutine_call, .return_push, .issue_interlocked, .issue_exempt,
    .pipe_empty, .write_buffer_empty, .issue_stall,
    .counter1_event_select, .counter0_event_select, .count_event,
    .counter_irq, .exc_entry, .exc_kind, .exc_pc, .exc_pc_exact,
    .firmware_return, .return_target, .return_to_native, .trap_valid,
    .trap_kinds, .trap_float, .trap_swc_mod, .trap_dest
  );

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Helpers; every task starts and ends just after a falling edge
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("compares %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic wr(input fcer_sel_t s, input logic [63:0] d);
    ipr_sel = s;
    ipr_wdata = d;
    mtpr_valid = 1'b1;
    @(negedge mclk);
    mtpr_valid = 1'b0;
  endtask : wr

  // Extra idle cycles keep summary reads far enough apart
  task automatic rd(input fcer_sel_t s, input logic [63:0] exp);
    ipr_sel = s;
    mfpr_valid = 1'b1;
    @(negedge mclk);
    mfpr_valid = 1'b0;
    chk(ipr_rvalid, 1'h1);
    chk(ipr_rdata, exp);
    cyc(3);
  endtask : rd

  // Control word in write layout, or in repacked read layout
  function automatic logic [63:0] cw(input logic rdf);
    if (rdf)
      return {30'h0, tg, 1'h0, en, 1'h0, c8, m1, m0, 6'h0, p1, p0, 1'h0};
    return {11'h0, tg, 1'h0, en, 1'h0, c8, m1, 20'h0, m0, 4'h0, p0,
      2'h0, p1};
  endfunction : cw

  task automatic setc;
    wr(FCER_SEL_CTRL, cw(1'b0));
    rd(FCER_SEL_CTRL, cw(1'b1));
  endtask : setc

  // c8 holds float, map, hw, dual, history, stack, predict, pipe
  task automatic probe;
    {issue_reserved, issue_float, kernel_mode, pal_mode} = 4'he;
    {subroutine_call, issue_interlocked, issue_exempt} = 3'h6;
    {pipe_empty, fetch_hit_raw, fetch_asm, itb_asm} = 4'h4;
    fetch_tag = tg;
    fetch_vpc = {2'h2, 7'h55, 21'h1abcd};
    itb_pa = 21'h0f0f0;
    #1;
    chk(illegal_opcode_fault, !c8[5]);
    chk(translation_reg_access_ok, 1'h0);
    chk(float_disabled_fault, !c8[7]);
    chk(dual_issue_allow, c8[4]);
    chk(predict_mode, c8[1] ? (c8[3] ? 2'h2 : 2'h1) : 2'h0);
    chk(return_push, c8[2]);
    chk(issue_stall, !c8[0]);
    chk(fill_tag, tg);
    chk(fetch_valid, 1'h1);
    chk({counter1_event_select, counter0_event_select}, {m1, m0});
    chk(fetch_pa, c8[6] ? fetch_vpc[33:13] : itb_pa);
    chk(fill_asm, c8[6]);
    fetch_tag = ~tg;
    {kernel_mode, pal_mode, issue_exempt} = 3'h3;
    #1;
    chk(fetch_valid, 1'h0);
    chk(fetch_pa, itb_pa);
    chk(fill_asm, 1'h0);
    chk(issue_stall, 1'h0);
    chk(illegal_opcode_fault, 1'h0);
    chk(translation_reg_access_ok, 1'h1);
    fetch_asm = 1'b1;
    #1;
    chk(fetch_valid, 1'h1);
  endtask : probe

  task automatic count_run(input int n, input int e0, input int e1);
    int c0, c1;
    c0 = 0;
    c1 = 0;
    count_event = 2'h3;
    for (int k = 0; k < n + 4; k++)
    begin
      if (k == n)
        count_event = 2'h0;
      @(negedge mclk);
      c0 += counter_irq[0];
      c1 += counter_irq[1];
    end
    chk(c0, e0);
    chk(c1, e1);
  endtask : count_run

  task automatic entry(input fcer_entry_t k, input logic [63:0] pc,
    input logic ex, input logic [63:0] exp);
    exc_kind = k;
    exc_pc = pc;
    exc_pc_exact = ex;
    exc_entry = 1'b1;
    @(negedge mclk);
    exc_entry = 1'b0;
    chk(return_target, exp);
    rd(FCER_SEL_EXCEPTION_RETURN_ADDRESS, exp);
  endtask : entry

  task automatic ret(input logic native);
    firmware_return = 1'b1;
    #1;
    chk(return_to_native, native);
    @(negedge mclk);
    firmware_return = 1'b0;
  endtask : ret

  task automatic trap(input logic [5:0] k, input logic s,
    input logic [5:0] d);
    trap_kinds = k;
    trap_swc_mod = s;
    trap_dest = d;
    {trap_float, trap_valid} = 2'h3;
    @(negedge mclk);
    trap_valid = 1'b0;
  endtask : trap

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_errors = 0;
    samples_checked = 0;
    resetn = 1'b0;
    {mtpr_valid, mfpr_valid, pal_mode, kernel_mode, issue_reserved} = '0;
    {issue_float, fetch_asm, fetch_hit_raw, itb_asm, subroutine_call} = '0;
    {issue_interlocked, issue_exempt, pipe_empty, write_buffer_empty} = '0;
    {exc_entry, exc_pc_exact, firmware_return, trap_valid} = '0;
    {trap_float, trap_swc_mod, count_event} = '0;
    {fetch_tag, trap_kinds, trap_dest, exc_pc, ipr_wdata} = '0;
    {fetch_vpc, itb_pa} = '0;
    ipr_sel = FCER_SEL_NONE;
    exc_kind = FCER_ENT_OTHER;
    cyc(6);
    resetn = 1'b1;
    // Tag and thresholds must survive a second reset
    {c8, tg, en, m1, m0, p0, p1} = {8'hff, 6'h2a, 2'h3, 3'h5, 4'ha, 2'h2};
    setc;
    resetn = 1'b0;
    cyc(6);
    resetn = 1'b1;
    {c8, en, m1, m0} = '0;
    rd(FCER_SEL_CTRL, cw(1'b1));
    probe;
    rd(FCER_SEL_EXCEPTION_RETURN_ADDRESS, 64'h0);
    rd(FCER_SEL_SUMMARY, 64'h0);
    wr(FCER_SEL_NONE, 64'hffff_ffff_ffff_ffff);
    rd(FCER_SEL_NONE, 64'h0);
    for (int i = 0; i < 4; i++)
    begin
      c8 = c8s[i];
      tg = c8[5:0];
      en = c8[1:0];
      m1 = c8[2:0];
      m0 = c8[7:4];
      {p0, p1} = {c8[0], c8[7]};
      setc;
      probe;
    end
    // Counters: each enable bit alone runs both, none stops both
    {c8, en, p0, p1} = {8'h00, 2'h1, 2'h3};
    setc;
    count_run(4096, 1, 16);
    {en, p0, p1} = {2'h2, 2'h0};
    setc;
    count_run(4096, 0, 1);
    en = 2'h0;
    setc;
    count_run(300, 0, 0);
    // Exception entries and returns
    pal_mode = 1'b0;
    entry(FCER_ENT_FCALL, 64'h1000, 1'b1, 64'h1004);
    entry(FCER_ENT_ARITHMETIC_TRAP_ENTRY, 64'h2008, 1'b1, 64'h200a);
    entry(FCER_ENT_MACHINE_CHECK_ENTRY, 64'h300c, 1'b0, 64'h300c);
    entry(FCER_ENT_OTHER, 64'h4010, 1'b1, 64'h4010);
    entry(FCER_ENT_RESET, 64'h5014, 1'b0, 64'h5014);
    ret(1'b1);
    pal_mode = 1'b1;
    entry(FCER_ENT_OTHER, 64'h6000, 1'b0, 64'h6001);
    ret(1'b0);
    pal_mode = 1'b0;
    wr(FCER_SEL_EXCEPTION_RETURN_ADDRESS, 64'h789c);
    rd(FCER_SEL_EXCEPTION_RETURN_ADDRESS, 64'h789c);
    // Summary: sticky kinds, software completion, mask window
    wr(FCER_SEL_SUMMARY, 64'h0);
    trap(6'h21, 1'b1, 6'h3f);
    rd(FCER_SEL_SUMMARY, 64'h2_0000_010c);
    trap(6'h02, 1'b0, 6'h3e);
    cyc(1);
    trap(6'h04, 1'b1, 6'h3c);
    // Mask holds bits 62 and 60; each read shifts it left once
    rd(FCER_SEL_SUMMARY, 64'h0000_0138);
    rd(FCER_SEL_SUMMARY, 64'h2_0000_0138);
    rd(FCER_SEL_SUMMARY, 64'h0000_0138);
    wr(FCER_SEL_SUMMARY, 64'hffff_ffff_ffff_ffff);
    rd(FCER_SEL_SUMMARY, 64'h2_0000_0000);
    for (int i = 0; i < 62; i++)
      rd(FCER_SEL_SUMMARY, 64'h0);
    end_sim;
  end

endmodule : fcer_regs_bench
